// [hdl/ctm_pkg.sv]
// Constants, timing counts and state encoding of the transceiver mode controller
package ctm_pkg;

    // Clock and link rates
    localparam int CLK_MHZ = 250;
    localparam int BIT_RATE_KBPS = 500;
    localparam int MIN_RATE_KBPS = 40;
    // Cycles per bit at the chosen bit rate
    localparam int BIT_CYC = (CLK_MHZ * 1000) / BIT_RATE_KBPS;
    // Longest bit allowed, from the lowest legal bit rate (rounded down)
    localparam int MAX_BIT_CYC = (CLK_MHZ * 1000) / MIN_RATE_KBPS;

    // Widths and depths
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 3;
    localparam int FIFO_DEPTH = 32;
    localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // Pin levels
    localparam logic PIN_RECESSIVE = 1'b1;
    localparam logic PIN_DOMINANT = 1'b0;
    localparam logic MODE_NORMAL = 1'b0;
    localparam logic MODE_STANDBY = 1'b1;

    // Controller states
    typedef enum logic [2:0] {
        CTM_ST_STANDBY = 3'b001,
        CTM_ST_IDLE = 3'b010,
        CTM_ST_SEND = 3'b100
    } ctm_state_e;

    // End of a bit period
    function automatic logic ctm_bit_end(input logic [CNT_W-1:0] cnt,
                                         input logic [CNT_W-1:0] period);
        ctm_bit_end = (cnt == (period - CNT_ONE));
    endfunction : ctm_bit_end

endpackage : ctm_pkg

// [hdl/ctm_fifo.sv]
// Parameterised valid/ready FIFO with registered full and empty flags
`timescale 1ns/10ps
module ctm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_EMPTY = '0;
    localparam logic [AW-1:0] PTR_ONE = AW'(1);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic full_r, full_nxt, empty_r, empty_nxt;
    logic rdy_r, rdy_nxt;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and flag next values
    always_comb begin
        push = in_valid_i && !full_r;
        pop = out_ready_i && !empty_r;
        wp_nxt = push ? wp_r + PTR_ONE : wp_r;
        rp_nxt = pop ? rp_r + PTR_ONE : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CNT_ONE;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CNT_ONE;
        end
        full_nxt = (cnt_nxt == CNT_FULL);
        empty_nxt = (cnt_nxt == CNT_EMPTY);
        // Ready leaves a flip-flop so the top output needs no gate
        rdy_nxt = !full_nxt;
    end

    // Flag and pointer registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
            rdy_r <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            empty_r <= empty_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // Storage array, written on accepted push
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    assign in_ready_o = rdy_r;
    assign out_valid_o = !empty_r;
    assign out_data_o = mem[rp_r];

    ////////////////////////////////////////////////////////////////////////////
    // Flags agree with the word count
    property p_fifo_flags;
        @(posedge clk_i) disable iff (!resetn_i)
        (full_r == (cnt_r == CNT_FULL)) && (empty_r == (cnt_r == CNT_EMPTY))
            && (rdy_r == !full_r);
    endproperty
    a_fifo_flags: assert property (p_fifo_flags) else $error("fifo flags disagree with count");

endmodule : ctm_fifo

// [hdl/ctm_host.sv]
// Controller that drives a CAN transceiver's transmit and mode-select pins
// Function
// [R01] Mode-select low requests Normal mode; transmit and receive are then active.
// [R02] In Normal mode the receive output follows the bus: low dominant.
// [R03] Mode-select high requests Standby, the transceiver low-power state.
// [R04] In Standby the transceiver's transmitter and normal receiver are off.
// [R05] Standby receive output only shows bus states longer than the wake filter.
// [R06] Low receive in Standby is a wake request; Standby holds until mode-select low.
// [R07] Transmit held low past the time-out disables the transmitter, bus recessive.
// [R08] Transmit returning high resets the transmit-dominant timer.
// [R09] Bit rate must be at least 40 kbit/s to avoid the transmit time-out.
// [R10] In Standby a recessive-to-dominant bus edge starts the bus-dominant timer.
// [R11] Bus dominant past its time-out in Standby forces receive output high.
// [R12] A dominant-to-recessive bus edge resets the bus-dominant timer.
// [R13] Transmit and mode-select pull up: unconnected means recessive and Standby.
// [R14] Hold transmit and mode-select high during Standby to save pull-up current.
// [R15] Main supply undervoltage forces Standby and ignores mode-select until recovery.
// [R16] I/O supply undervoltage switches the transceiver off with zero bus load; the bench model still drives split_on_o high in Normal.
// [R17] Overtemperature disables drivers until cool and transmit back recessive.
// [R18] Common-mode output is half supply in Normal, floating otherwise.
// [R19] In Standby the bus lines are biased towards ground.
// [R20] The low-power receiver runs from the I/O supply alone.
// [R21] Filter and time-out durations are independent configurable timers.
`timescale 1ns/10ps
module ctm_host #(
    parameter logic [15:0] BIT_CYC = 16'(ctm_pkg::BIT_CYC),
    parameter int MAX_BIT_CYC = ctm_pkg::MAX_BIT_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic normal_req_i,
    input wire logic [ctm_pkg::BYTE_W-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic rx_i,
    output logic tx_o,
    output logic mode_select_o,
    output logic rx_o,
    output logic wake_o,
    output logic busy_o
);
    ctm_pkg::ctm_state_e state_r, state_nxt;
    logic [ctm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ctm_pkg::IDX_W-1:0] idx_r, idx_nxt;
    logic [ctm_pkg::BYTE_W-1:0] shift_r, shift_nxt;
    logic tx_r, tx_nxt, mode_r, mode_nxt, rx_r, rx_nxt, wake_r, wake_nxt, busy_r, busy_nxt;
    logic pop;
    logic fifo_valid;
    logic [ctm_pkg::BYTE_W-1:0] fifo_data;

    ////////////////////////////////////////////////////////////////////////////
    // Byte buffer; drains only in Normal mode, so it fills in Standby
    ctm_fifo #(
        .WIDTH(ctm_pkg::BYTE_W),
        .DEPTH(ctm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode and serializer next values
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        pop = 1'b0;
        unique case (state_r)
            ctm_pkg::CTM_ST_STANDBY: begin
                // [R14] transmit held recessive
                tx_nxt = ctm_pkg::PIN_RECESSIVE;
                // [R06] leave Standby only on request
                if (normal_req_i) begin
                    state_nxt = ctm_pkg::CTM_ST_IDLE;
                end
            end
            ctm_pkg::CTM_ST_IDLE: begin
                tx_nxt = ctm_pkg::PIN_RECESSIVE;
                if (!normal_req_i) begin
                    state_nxt = ctm_pkg::CTM_ST_STANDBY;
                end else if (fifo_valid) begin
                    pop = 1'b1;
                    shift_nxt = fifo_data;
                    idx_nxt = ctm_pkg::IDX_FIRST;
                    cnt_nxt = ctm_pkg::CNT_ZERO;
                    tx_nxt = fifo_data[ctm_pkg::BYTE_W-1];
                    state_nxt = ctm_pkg::CTM_ST_SEND;
                end
            end
            ctm_pkg::CTM_ST_SEND: begin
                cnt_nxt = cnt_r + ctm_pkg::CNT_ONE;
                // [R09] each bit lasts BIT_CYC cycles
                if (ctm_pkg::ctm_bit_end(cnt_r, BIT_CYC)) begin
                    cnt_nxt = ctm_pkg::CNT_ZERO;
                    if (idx_r != ctm_pkg::IDX_LAST) begin
                        idx_nxt = idx_r + 3'h1;
                        shift_nxt = {shift_r[ctm_pkg::BYTE_W-2:0], 1'b0};
                        tx_nxt = shift_r[ctm_pkg::BYTE_W-2];
                    end else if (normal_req_i && fifo_valid) begin
                        pop = 1'b1;
                        shift_nxt = fifo_data;
                        idx_nxt = ctm_pkg::IDX_FIRST;
                        tx_nxt = fifo_data[ctm_pkg::BYTE_W-1];
                    end else begin
                        // [R08] return transmit high after the frame
                        tx_nxt = ctm_pkg::PIN_RECESSIVE;
                        state_nxt = ctm_pkg::CTM_ST_IDLE;
                    end
                end
            end
        endcase
        // [R01] low select outside Standby, [R03] high in Standby
        mode_nxt = (state_nxt == ctm_pkg::CTM_ST_STANDBY) ? ctm_pkg::MODE_STANDBY
                                                           : ctm_pkg::MODE_NORMAL;
        busy_nxt = (state_nxt == ctm_pkg::CTM_ST_SEND);
    end

    // Mode and serializer registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ctm_pkg::CTM_ST_STANDBY;
            cnt_r <= ctm_pkg::CNT_ZERO;
            idx_r <= ctm_pkg::IDX_FIRST;
            shift_r <= '0;
            tx_r <= ctm_pkg::PIN_RECESSIVE;
            mode_r <= ctm_pkg::MODE_STANDBY;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            mode_r <= mode_nxt;
            busy_r <= busy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive sampling and wake report
    always_comb begin
        rx_nxt = rx_i;
        // [R06] low receive while in Standby flags a wake request
        wake_nxt = (state_r == ctm_pkg::CTM_ST_STANDBY) && (rx_r == ctm_pkg::PIN_DOMINANT);
    end

    // Receive registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_r <= ctm_pkg::PIN_RECESSIVE;
            wake_r <= 1'b0;
        end else begin
            rx_r <= rx_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign tx_o = tx_r;
    assign mode_select_o = mode_r;
    assign rx_o = rx_r;
    assign wake_o = wake_r;
    assign busy_o = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Helper: length of the current dominant run on transmit
    logic [31:0] dom_run_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dom_run_r <= '0;
        end else begin
            dom_run_r <= (tx_r == ctm_pkg::PIN_DOMINANT) ? dom_run_r + 32'h1 : 32'h0;
        end
    end

    property p_mode_normal;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_r != ctm_pkg::CTM_ST_STANDBY) |-> (mode_select_o == ctm_pkg::MODE_NORMAL);
    endproperty
    a_mode_normal: assert property (p_mode_normal) else $error("select not low outside standby"); // [R01]

    property p_mode_standby;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_r == ctm_pkg::CTM_ST_IDLE && !normal_req_i) |=> (mode_select_o == ctm_pkg::MODE_STANDBY);
    endproperty
    a_mode_standby: assert property (p_mode_standby) else $error("standby not selected"); // [R03]

    property p_standby_tx;
        @(posedge clk_i) disable iff (!resetn_i)
        (mode_select_o == ctm_pkg::MODE_STANDBY) |-> (tx_o == ctm_pkg::PIN_RECESSIVE);
    endproperty
    a_standby_tx: assert property (p_standby_tx) else $error("transmit not high in standby"); // [R14]

    property p_wake;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_r == ctm_pkg::CTM_ST_STANDBY && rx_r == ctm_pkg::PIN_DOMINANT) |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake request not reported"); // [R06]

    property p_stay_standby;
        @(posedge clk_i) disable iff (!resetn_i)
        (state_r == ctm_pkg::CTM_ST_STANDBY && !normal_req_i) |=> (mode_select_o == ctm_pkg::MODE_STANDBY);
    endproperty
    a_stay_standby: assert property (p_stay_standby) else $error("standby left without request"); // [R06]

    property p_bit_edge;
        @(posedge clk_i) disable iff (!resetn_i)
        ($changed(tx_o) && $past(state_r) == ctm_pkg::CTM_ST_SEND)
            |-> ($past(cnt_r) == BIT_CYC - ctm_pkg::CNT_ONE);
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("transmit changed inside a bit"); // [R09]

    property p_dom_run;
        @(posedge clk_i) disable iff (!resetn_i)
        dom_run_r <= ctm_pkg::BYTE_W * int'(BIT_CYC) && int'(BIT_CYC) <= MAX_BIT_CYC;
    endproperty
    a_dom_run: assert property (p_dom_run) else $error("dominant run too long"); // [R09]

    property p_bit_cnt;
        @(posedge clk_i) disable iff (!resetn_i)
        cnt_r < BIT_CYC;
    endproperty
    a_bit_cnt: assert property (p_bit_cnt) else $error("bit counter past period"); // [R09]

endmodule : ctm_host

// [bench/ctm_xcvr_model.sv]
// Behavioural transceiver: mode pin, wake filter and dominant time-outs
`timescale 1ns/10ps
module ctm_xcvr_model #(
    parameter int FLTR_CYC = 3,
    parameter int TXD_TO_CYC = 6250,
    parameter int BUS_TO_CYC = 40
) (
    input wire logic clk_i,
    input wire logic tx_i,
    input wire logic mode_select_i,
    input wire logic other_dom_i,
    input wire logic main_uv_i,
    input wire logic io_uv_i,
    input wire logic hot_i,
    output logic rx_o,
    output logic split_on_o
);
    int txd_cnt = 0;
    int flt_cnt = 0;
    int bus_cnt = 0;
    logic flt_r = 1'b1;
    logic drv_off = 1'b0;
    logic tx_high;
    logic stby;
    logic bus_dom;
    assign tx_high = (tx_i !== 1'b0);
    // main-supply undervoltage forces Standby and ignores the select pin
    assign stby = main_uv_i || (mode_select_i !== 1'b0);
    // drivers off while hot, back on once cool and transmit recessive
    always @(posedge clk_i) begin
        if (hot_i) begin
            drv_off <= 1'b1;
        end else if (tx_high) begin
            drv_off <= 1'b0;
        end
    end
    always @(posedge clk_i) begin
        txd_cnt <= tx_high ? 0 : txd_cnt + 1;
    end
    // own driver only in Normal, off after time-out
    // no drive at all while the I/O supply is low
    assign bus_dom = other_dom_i | (!stby && !tx_high && txd_cnt <= TXD_TO_CYC
                                    && !io_uv_i && !hot_i && !drv_off);
    always @(posedge clk_i) begin
        if (flt_r == bus_dom) begin
            flt_cnt <= (flt_cnt >= FLTR_CYC - 1) ? 0 : flt_cnt + 1;
            flt_r <= (flt_cnt >= FLTR_CYC - 1) ? !bus_dom : flt_r;
        end else begin
            flt_cnt <= 0;
        end
    end
    always @(posedge clk_i) begin
        bus_cnt <= (stby && bus_dom) ? bus_cnt + 1 : 0;
    end
    // receiver off and output high while the I/O supply is low
    assign rx_o = io_uv_i ? 1'b1 : stby ? (flt_r | (bus_cnt > BUS_TO_CYC)) : !bus_dom;
    // common-mode output driven only in Normal mode
    assign split_on_o = !stby;
endmodule : ctm_xcvr_model

// [bench/ctm_host_test.sv]
// Self-checking bench for the transceiver mode controller
`timescale 1ns/10ps
module ctm_host_test;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic normal_req_i = 1'b0;
    logic [ctm_pkg::BYTE_W-1:0] tx_data_i = 8'h00;
    logic tx_valid_i = 1'b0;
    logic other_dom = 1'b0;
    logic main_uv = 1'b0;
    logic io_uv = 1'b0;
    logic hot = 1'b0;
    logic split_on;
    logic rx_i, tx_o, mode_select_o, rx_o, wake_o, busy_o, tx_ready_o;
    int miscompares = 0;
    int compares = 0;

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    ctm_host #(.BIT_CYC(16'h0004), .MAX_BIT_CYC(6250)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .normal_req_i(normal_req_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_i(rx_i), .tx_o(tx_o), .mode_select_o(mode_select_o), .rx_o(rx_o),
        .wake_o(wake_o), .busy_o(busy_o));
    ctm_xcvr_model #(.FLTR_CYC(3), .TXD_TO_CYC(6250), .BUS_TO_CYC(40)) peer (
        .clk_i(clk_i), .tx_i(tx_o), .mode_select_i(mode_select_o),
        .other_dom_i(other_dom), .main_uv_i(main_uv), .io_uv_i(io_uv), .hot_i(hot),
        .rx_o(rx_i), .split_on_o(split_on));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Push n bytes base, base+1, ... holding valid until ready
    task automatic fill(input int n, input logic [7:0] base);
        int k;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            tx_valid_i = 1'b1;
            tx_data_i = base + 8'(i);
            k = 0;
            while (tx_ready_o !== 1'b1 && k < 100) begin
                @(negedge clk_i);
                k++;
            end
            chk("tx_ready_o", 1'b1, tx_ready_o);
            @(posedge clk_i);
        end
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask : fill

    // Follow the serial stream bit by bit, mid-bit
    task automatic send_check(input int n, input logic [7:0] base);
        int k;
        logic [7:0] b;
        k = 0;
        while (busy_o !== 1'b1 && k < 50) begin
            @(negedge clk_i);
            k++;
        end
        chk("mode_select_o", ctm_pkg::MODE_NORMAL, mode_select_o);
        @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            b = base + 8'(i);
            for (int j = 7; j >= 0; j--) begin
                chk("tx_o", b[j], tx_o);
                chk("rx_o", b[j], rx_o);
                cyc(4);
            end
        end
        chk("busy_o", 1'b0, busy_o);
        chk("tx_o", ctm_pkg::PIN_RECESSIVE, tx_o);
    endtask : send_check

    task automatic wait_wake(input logic lvl);
        int k;
        k = 0;
        while (wake_o !== lvl && k < 20) begin
            @(negedge clk_i);
            k++;
        end
    endtask : wait_wake

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        @(negedge clk_i);
        chk("mode_select_o", ctm_pkg::MODE_STANDBY, mode_select_o);
        chk("tx_o", ctm_pkg::PIN_RECESSIVE, tx_o);
        chk("wake_o", 1'b0, wake_o);
        chk("busy_o", 1'b0, busy_o);
        chk("tx_ready_o", 1'b1, tx_ready_o);
    endtask : t_reset

    // Bytes queued in Standby go out back to back after Normal
    task automatic t_stream(input int n, input logic [7:0] base);
        fill(n, base);
        cyc(10);
        chk("tx_o", ctm_pkg::PIN_RECESSIVE, tx_o);
        chk("tx_ready_o", n < 32, tx_ready_o);
        normal_req_i = 1'b1;
        send_check(n, base);
        chk("tx_ready_o", 1'b1, tx_ready_o);
        normal_req_i = 1'b0;
        cyc(3);
        chk("mode_select_o", ctm_pkg::MODE_STANDBY, mode_select_o);
        chk("tx_o", ctm_pkg::PIN_RECESSIVE, tx_o);
    endtask : t_stream

    // Wake requests through filter and bus time-out
    task automatic t_wake();
        other_dom = 1'b1;
        wait_wake(1'b1);
        chk("wake_o", 1'b1, wake_o);
        chk("mode_select_o", ctm_pkg::MODE_STANDBY, mode_select_o);
        cyc(50);
        chk("wake_o", 1'b0, wake_o);
        other_dom = 1'b0;
        cyc(10);
        other_dom = 1'b1;
        cyc(2);
        other_dom = 1'b0;
        cyc(10);
        chk("wake_o", 1'b0, wake_o);
        other_dom = 1'b1;
        wait_wake(1'b1);
        chk("wake_o", 1'b1, wake_o);
        other_dom = 1'b0;
        wait_wake(1'b0);
        chk("wake_o", 1'b0, wake_o);
    endtask : t_wake

    // Supply and thermal responses of the transceiver seen at the host pins and at split_on
    task automatic t_fault();
        chk("split_on", 1'b0, split_on);
        normal_req_i = 1'b1;
        cyc(3);
        chk("split_on", 1'b1, split_on);
        main_uv = 1'b1;
        other_dom = 1'b1;
        cyc(1);
        chk("split_on", 1'b0, split_on);
        chk("rx_o", 1'b1, rx_o);
        cyc(6);
        chk("rx_o", 1'b0, rx_o);
        io_uv = 1'b1;
        cyc(2);
        chk("rx_o", 1'b1, rx_o);
        io_uv = 1'b0;
        main_uv = 1'b0;
        other_dom = 1'b0;
        hot = 1'b1;
        fill(1, 8'h0F);
        cyc(2);
        chk("tx_o", 1'b0, tx_o);
        chk("rx_o", 1'b1, rx_o);
        hot = 1'b0;
        cyc(4);
        chk("tx_o", 1'b0, tx_o);
        chk("rx_o", 1'b1, rx_o);
        cyc(40);
        fill(1, 8'h0F);
        cyc(2);
        chk("rx_o", 1'b0, rx_o);
    endtask : t_fault

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        cyc(3);
        resetn_i = 1'b1;
        t_reset();
        t_stream(2, 8'hA5);
        t_stream(32, 8'h10);
        t_wake();
        t_fault();
        conclude();
    end

    initial begin
        #80000;
        miscompares++;
        conclude();
    end
endmodule : ctm_host_test
